// [common/agen_regs.vh]
`ifndef AGEN_REGS_VH
`define AGEN_REGS_VH
// Page select registers
`define PAGE_RESET         10'h001
`define PAGE_ZERO          10'h000
`define PAGE_PROG_MIN      10'h200
`define PAGE_PROG_BIT      9
`define WPAGE_RESET        9'h001
`define WPAGE_ZERO         9'h000
// Base space
`define BASE_ALWAYS_TOP    16'h2FFF
`define BASE_UPPER_BIT     15
`define NEAR_FIELD_W       13
// Stack
`define SP_RESET           16'h1000
`define STEP_WORD          16'h0002
// Pointer register numbers
`define PTR_SP             4'hF
`define PTR_FP             4'hE
`define MAC_REG_FIRST      4'h8
`define MAC_REG_LAST       4'hB
`define MAC_X_IDX          4'h9
`define MAC_Y_IDX          4'hB
`define MAC_STEP_1         4'h2
`define MAC_STEP_2         4'h4
`define MAC_STEP_3         4'h6
// Addressing modes
`define AM_DIRECT          3'h0
`define AM_INDIRECT        3'h1
`define AM_POST            3'h2
`define AM_PRE             3'h3
`define AM_INDEXED         3'h4
`define AM_LIT_OFS         3'h5
`define AM_FILE            3'h6
`define AM_LITERAL         3'h7
// Stack operations
`define SO_NONE            3'h0
`define SO_PUSH            3'h1
`define SO_POP             3'h2
`define SO_CALL            3'h3
`define SO_EXC             3'h4
`define SO_RET             3'h5
// Register port map
`define REG_RPAGE          4'h0
`define REG_WPAGE          4'h1
`define REG_SP             4'h2
`define REG_FP             4'h3
`define REG_FLAGS          4'h4
`endif

// [core/data_address_generation.v]
`include "agen_regs.vh"
`default_nettype none
module data_address_generation (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   input  wire        clk_en,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // Operand request from decode
   input  wire        op_valid,
   input  wire        op_is_write,
   input  wire        op_move_class,
   input  wire        op_mac_class,
   input  wire [2:0]  op_mode,
   input  wire [3:0]  op_ptr_sel,
   input  wire [15:0] op_ptr_val,
   input  wire [15:0] op_base_val,
   input  wire [15:0] op_lit,
   input  wire [3:0]  op_mod,
   input  wire        op_mod_dec,
   input  wire [12:0] op_file_addr,
   input  wire        frame_pointer_active,
   // Stack request from decode
   input  wire [2:0]  stack_op,
   input  wire [15:0] stack_wdata,
   input  wire [22:0] pc_value,
   input  wire [7:0]  status_low_byte,
   // Operand result
   output reg         addr_valid,
   output reg  [23:0] ext_addr,
   output reg         addr_prog_space,
   output reg         addr_is_write,
   output reg  [15:0] ptr_wb_val,
   output reg         ptr_wb_en,
   output reg  [3:0]  ptr_wb_sel,
   output reg         addr_error,
   output reg         mode_error,
   // Stack memory port
   output reg         stk_valid,
   output reg         stk_write,
   output reg  [15:0] stk_addr,
   output reg  [15:0] stk_wdata,
   output reg  [15:0] sp_out
);
   // ****************************************
   // State
   // ****************************************
   // One-hot stack sequencer states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_HIGH = 3'b010;
   localparam [2:0] ST_POP2 = 3'b100;
   reg [9:0]  rpage_r;
   reg [8:0]  wpage_r;
   reg [15:0] sp_r;
   reg [15:0] fp_r;
   reg [2:0]  st_r;
   reg [15:0] hi_word_r;
   reg [15:0] sp_nxt;

   // ****************************************
   // Software write decode
   // ****************************************
   // A zero page write is dropped, so the upper half never reaches page zero
   // through software; the write page has no program-space bit at all
   wire        rpage_sw_wr = reg_wr && (reg_addr == `REG_RPAGE)
                             && (reg_wdata[9:0] != `PAGE_ZERO);
   wire        wpage_sw_wr = reg_wr && (reg_addr == `REG_WPAGE)
                             && (reg_wdata[8:0] != `WPAGE_ZERO);
   wire        fp_sw_wr    = reg_wr && (reg_addr == `REG_FP);
   wire        sp_sw_wr    = reg_wr && (reg_addr == `REG_SP);
   wire [15:0] sp_sw_val   = {reg_wdata[15:1], 1'b0};

   // ****************************************
   // Register read mux
   // ****************************************
   // Unmapped offsets and idle cycles read as zero;
   // the registered copy stands only in the cycle after the strobe
   reg [15:0] rdata_nxt;
   always @* begin
      rdata_nxt = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `REG_RPAGE: rdata_nxt = {6'h00, rpage_r};
            `REG_WPAGE: rdata_nxt = {7'h00, wpage_r};
            `REG_SP: rdata_nxt = sp_r;
            `REG_FP: rdata_nxt = fp_r;
            `REG_FLAGS: rdata_nxt = {13'h0000, st_r};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   // ****************************************
   // Multiply-accumulate operand limits
   // ****************************************
   // Pointers eight and nine feed the X read unit, ten and eleven the Y unit;
   // any other pointer or mode is flagged on mode_error, never as an address
   reg mac_reg_bad;
   reg mac_idx_bad;
   reg mac_step_bad;
   reg mac_mode_bad;
   reg mac_bad;
   always @* begin
      mac_reg_bad = (op_ptr_sel < `MAC_REG_FIRST) || (op_ptr_sel > `MAC_REG_LAST);
      // Register offset form exists for one X and one Y pointer only
      mac_idx_bad = 1'b0;
      if (op_mode == `AM_INDEXED) begin
         if (op_ptr_sel != `MAC_X_IDX && op_ptr_sel != `MAC_Y_IDX)
            mac_idx_bad = 1'b1;
      end
      // Post-modify steps are fixed: two, four or six
      // Decrementing steps are not offered to this class
      mac_step_bad = 1'b0;
      if (op_mode == `AM_POST) begin
         if (op_mod_dec)
            mac_step_bad = 1'b1;
         else if (op_mod != `MAC_STEP_1 && op_mod != `MAC_STEP_2 && op_mod != `MAC_STEP_3)
            mac_step_bad = 1'b1;
      end
      case (op_mode)
         `AM_INDIRECT: mac_mode_bad = 1'b0;
         `AM_POST: mac_mode_bad = 1'b0;
         `AM_INDEXED: mac_mode_bad = 1'b0;
         default: mac_mode_bad = 1'b1;
      endcase
      mac_bad = mac_reg_bad || mac_idx_bad || mac_step_bad || mac_mode_bad;
   end

   // ****************************************
   // Effective address
   // ****************************************
   reg [15:0] ea;
   reg [15:0] mod_val;
   reg [15:0] ptr_nxt;
   reg        wb;
   reg        bad_mode;
   reg        upper;
   reg        is_stack_ptr;
   reg [9:0]  page;
   reg [23:0] xa;
   reg        trap;
   reg        prog;
   always @* begin
      // Decrement is the two's complement of the modify amount
      mod_val = op_mod_dec ? (16'h0000 - {12'h000, op_mod}) : {12'h000, op_mod};
      ea = op_ptr_val;
      ptr_nxt = op_ptr_val;
      wb = 1'b0;
      bad_mode = 1'b0;
      case (op_mode)
         `AM_INDIRECT: ea = op_ptr_val;
         `AM_POST: begin
            ea = op_ptr_val;
            ptr_nxt = op_ptr_val + mod_val;
            wb = 1'b1;
         end
         `AM_PRE: begin
            ea = op_ptr_val + mod_val;
            ptr_nxt = ea;
            wb = 1'b1;
         end
         `AM_INDEXED: begin
            ea = op_ptr_val + op_base_val;
            bad_mode = !(op_move_class || op_mac_class);
         end
         `AM_LIT_OFS: ea = op_ptr_val + op_lit;
         `AM_FILE: ea = {3'h0, op_file_addr};
         default: ea = op_ptr_val;
      endcase
      if (op_mac_class && mac_bad)
         bad_mode = 1'b1;
      // The stack pointer, and the frame pointer while frame_pointer_active is set, are never paged
      is_stack_ptr = (op_ptr_sel == `PTR_SP) || (op_ptr_sel == `PTR_FP && frame_pointer_active);
      upper = ea[`BASE_UPPER_BIT] && !is_stack_ptr && op_mode != `AM_FILE;
      // Sources use the read page, destinations the write page
      page = op_is_write ? {1'b0, wpage_r} : rpage_r;
      trap = 1'b0;
      prog = 1'b0;
      if (upper) begin
         xa = {page[8:0], ea[14:0]};
         // Page zero through the upper half would alias base memory
         if (page == `PAGE_ZERO) trap = 1'b1;
         if (!op_is_write && page[`PAGE_PROG_BIT]) prog = 1'b1;
      end else begin
         xa = {8'h00, ea};
      end
   end

   // ****************************************
   // Registers and stack
   // ****************************************
   // Call and exception push two words over two cycles; return pops two.
   // A stack request during the second cycle is ignored.
   always @* begin
      sp_nxt = sp_r;
      case (st_r)
         ST_IDLE: begin
            case (stack_op)
               `SO_PUSH, `SO_CALL, `SO_EXC: sp_nxt = sp_r + `STEP_WORD;
               `SO_POP, `SO_RET: sp_nxt = sp_r - `STEP_WORD;
               default: sp_nxt = sp_r;
            endcase
         end
         ST_HIGH: sp_nxt = sp_r + `STEP_WORD;
         ST_POP2: sp_nxt = sp_r - `STEP_WORD;
         default: sp_nxt = sp_r;
      endcase
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rpage_r <= `PAGE_RESET;
         wpage_r <= `WPAGE_RESET;
         sp_r <= `SP_RESET;
         fp_r <= 16'h0000;
         st_r <= ST_IDLE;
         hi_word_r <= 16'h0000;
         reg_rdata <= 16'h0000;
         addr_valid <= 1'b0;
         ext_addr <= 24'h000000;
         addr_prog_space <= 1'b0;
         addr_is_write <= 1'b0;
         ptr_wb_val <= 16'h0000;
         ptr_wb_en <= 1'b0;
         ptr_wb_sel <= 4'h0;
         addr_error <= 1'b0;
         mode_error <= 1'b0;
         stk_valid <= 1'b0;
         stk_write <= 1'b0;
         stk_addr <= 16'h0000;
         stk_wdata <= 16'h0000;
         sp_out <= `SP_RESET;
      end else if (clk_en) begin
         reg_rdata <= rdata_nxt;
         if (rpage_sw_wr)
            rpage_r <= reg_wdata[9:0];
         if (wpage_sw_wr)
            wpage_r <= reg_wdata[8:0];
         if (fp_sw_wr)
            fp_r <= reg_wdata;
         // Software write wins over stack activity; bit zero always cleared
         if (sp_sw_wr)
            sp_r <= sp_sw_val;
         else
            sp_r <= {sp_nxt[15:1], 1'b0};
         sp_out <= sp_sw_wr ? sp_sw_val : {sp_nxt[15:1], 1'b0};
         // Operand result: one cycle after the request, standing one cycle.
         // A trap or an illegal mode blocks the access and the write-back.
         addr_valid <= op_valid && !trap && !bad_mode && !(prog && op_is_write);
         ext_addr <= xa;
         addr_prog_space <= op_valid && prog;
         addr_is_write <= op_is_write;
         addr_error <= op_valid && trap;
         mode_error <= op_valid && bad_mode;
         ptr_wb_en <= op_valid && wb && !trap && !bad_mode;
         ptr_wb_val <= ptr_nxt;
         ptr_wb_sel <= op_ptr_sel;
         // Stack sequence
         // Stack addresses stay in base space whatever the page registers hold
         stk_valid <= 1'b0;
         stk_write <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               case (stack_op)
                  `SO_PUSH: begin
                     stk_valid <= 1'b1;
                     stk_write <= 1'b1;
                     stk_addr <= sp_r;
                     stk_wdata <= stack_wdata;
                  end
                  `SO_CALL, `SO_EXC: begin
                     stk_valid <= 1'b1;
                     stk_write <= 1'b1;
                     stk_addr <= sp_r;
                     stk_wdata <= pc_value[15:0];
                     hi_word_r <= (stack_op == `SO_EXC) ?
                        {status_low_byte, 1'b0, pc_value[22:16]} :
                        {8'h00, 1'b0, pc_value[22:16]};
                     st_r <= ST_HIGH;
                  end
                  `SO_POP: begin
                     stk_valid <= 1'b1;
                     stk_addr <= sp_r - 16'h0002;
                  end
                  `SO_RET: begin
                     stk_valid <= 1'b1;
                     stk_addr <= sp_r - 16'h0002;
                     st_r <= ST_POP2;
                  end
                  default: st_r <= ST_IDLE;
               endcase
            end
            ST_HIGH: begin
               stk_valid <= 1'b1;
               stk_write <= 1'b1;
               stk_addr <= sp_r;
               stk_wdata <= hi_word_r;
               st_r <= ST_IDLE;
            end
            ST_POP2: begin
               stk_valid <= 1'b1;
               stk_addr <= sp_r - 16'h0002;
               st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [tb/agen_monitor.sv]
`default_nettype none
module agen_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        clk_en,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Operand request and result
   input wire logic        op_valid,
   input wire logic        op_is_write,
   input wire logic        op_mac_class,
   input wire logic [2:0]  op_mode,
   input wire logic [3:0]  op_ptr_sel,
   input wire logic [15:0] op_ptr_val,
   input wire logic [15:0] op_base_val,
   input wire logic [3:0]  op_mod,
   input wire logic        op_mod_dec,
   input wire logic        addr_valid,
   input wire logic [23:0] ext_addr,
   input wire logic        addr_prog_space,
   input wire logic [15:0] ptr_wb_val,
   input wire logic        ptr_wb_en,
   input wire logic        addr_error,
   // Stack
   input wire logic [15:0] sp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] rpage_r;
   logic       rd_up;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Shadow of the read page select, zero writes ignored
   always_ff @(posedge clk or posedge reset)
      if (reset) rpage_r <= 10'h001;
      else if (clk_en && reg_wr && reg_addr == 4'h0 && reg_wdata[9:0] != 10'h000)
         rpage_r <= reg_wdata[9:0];
   assign rd_up = op_valid && clk_en && op_mode == 3'h1 && !op_is_write && !op_mac_class
                  && op_ptr_val[15] && op_ptr_sel < 4'hE;
   a_sp_aligned: assert property (sp_out[0] == 1'b0)
      else $error("stack pointer odd");
   a_sp_read_even: assert property ($past(reg_rd) && $past(reg_addr) == 4'h2
      |-> !reg_rdata[0])
      else $error("stack pointer read odd");
   a_low_page0: assert property (op_valid && clk_en && op_mode == 3'h1 && !op_mac_class
      && op_ptr_val <= 16'h2FFF |=> addr_valid && ext_addr == {8'h00, $past(op_ptr_val)})
      else $error("low base address not page zero");
   a_read_page: assert property (rd_up && !rpage_r[9]
      |=> ext_addr == {$past(rpage_r[8:0]), $past(op_ptr_val[14:0])})
      else $error("read page not concatenated");
   a_prog_read: assert property (rd_up && rpage_r[9] |=> addr_prog_space && addr_valid)
      else $error("program page read not marked");
   a_trap_blocks: assert property (addr_error |-> !addr_valid)
      else $error("trap completed as access");
   a_post_modify: assert property (op_valid && clk_en && op_mode == 3'h2 && !op_mac_class
      && !op_mod_dec |=> ptr_wb_en && ptr_wb_val == $past(op_ptr_val) + $past(op_mod))
      else $error("post modify write-back wrong");
   a_pre_modify: assert property (op_valid && clk_en && op_mode == 3'h3 && !op_mac_class
      && !op_mod_dec && op_ptr_val < 16'h2000
      |=> ext_addr == {8'h00, $past(op_ptr_val) + $past(op_mod)})
      else $error("pre modify address wrong");
   a_indexed_sum: assert property (op_valid && clk_en && op_mode == 3'h4 && !op_mac_class
      && op_ptr_val < 16'h1000 && op_base_val < 16'h1000
      |=> ext_addr == {8'h00, $past(op_ptr_val) + $past(op_base_val)})
      else $error("indexed address wrong");
endmodule
bind data_address_generation agen_monitor u_agen_monitor (.*);
`default_nettype wire

// [tb/stack_memory_model.sv]
`default_nettype none
module stack_memory_model (
   // Clock
   input wire logic        clk,
   // Stack memory port
   input wire logic        stk_valid,
   input wire logic        stk_write,
   input wire logic [15:0] stk_addr,
   input wire logic [15:0] stk_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:32767];
   // Word store over the whole unpaged base space
   always @(posedge clk)
      if (stk_valid && stk_write) mem[stk_addr[15:1]] <= stk_wdata;
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, reg_wr, reg_rd, op_valid, op_is_write, op_mod_dec;
   logic        addr_valid, addr_prog_space, ptr_wb_en, addr_error, stk_valid, stk_write;
   logic [3:0]  reg_addr, op_mod;
   logic [2:0]  op_mode, stack_op;
   logic [15:0] reg_wdata, op_ptr_val, op_base_val, stack_wdata, reg_rdata;
   logic [15:0] ptr_wb_val, stk_addr, stk_wdata, sp_out;
   logic [22:0] pc_value;
   logic [7:0]  status_low_byte;
   logic [23:0] ext_addr;
   logic        clk_en, op_move_class, op_mac_class, mode_error;
   logic [3:0]  op_ptr_sel;
   int          n_errors = 0;
   int          total_checks = 0;
   data_address_generation u_data_address_generation (
      .*,
      .op_file_addr        (op_ptr_val[12:0]),
      .op_lit              (op_base_val),
      .frame_pointer_active(1'b0),
      .addr_is_write       (),
      .ptr_wb_sel          ()
   );
   stack_memory_model u_stack_memory_model (.*);
   task automatic finish_test;
      if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // Zero expected address means only validity is compared
   task automatic op(input logic [2:0] m, input logic w, input logic [15:0] p, b,
                     input logic [4:0] md, input logic [23:0] exp);
      @(posedge clk);
      {op_mode, op_is_write, op_ptr_val, op_base_val} <= {m, w, p, b};
      {op_mod_dec, op_mod, op_valid} <= {md, 1'b1};
      @(posedge clk);
      op_valid <= 1'b0;
      #1 chk({addr_valid, addr_error}, 2'b10);
      if (exp !== 24'h0) chk(ext_addr, exp);
   endtask
   // Class limits: expects either a clean access or a mode error
   task automatic cls(input logic mv, mc, input logic [2:0] md, input logic [3:0] sel,
                      input logic [4:0] mo, input logic bad);
      @(posedge clk);
      {op_move_class, op_mac_class, op_mode, op_ptr_sel} <= {mv, mc, md, sel};
      {op_mod_dec, op_mod, op_ptr_val, op_is_write, op_valid} <= {mo, 16'h0100, 1'b0, 1'b1};
      @(posedge clk);
      {op_move_class, op_mac_class, op_ptr_sel, op_valid} <= {1'b1, 1'b0, 4'h1, 1'b0};
      #1 chk({addr_valid, mode_error}, {!bad, bad});
   endtask
   task automatic st(input logic [2:0] s);
      @(posedge clk);
      stack_op <= s;
      @(posedge clk);
      stack_op <= 3'h0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] m(input logic [15:0] a);
      return u_stack_memory_model.mem[a[15:1]];
   endfunction
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      finish_test;
   end
   // ********************************************************
   // Main sequence
   // ********************************************************
   initial begin
      reset = 1'b1;
      {reg_wr, reg_rd, op_valid, op_is_write, op_mod_dec, reg_addr, op_mod, op_mode, stack_op,
       reg_wdata, op_ptr_val, op_base_val} = '0;
      {stack_wdata, pc_value, status_low_byte} = {16'hABCD, 23'h7A1234, 8'h5A};
      {clk_en, op_move_class, op_mac_class, op_ptr_sel} = {1'b1, 1'b1, 1'b0, 4'h1};
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rdc(4'h0, 16'h0001);
      rdc(4'h1, 16'h0001);
      rdc(4'h2, 16'h1000);
      rdc(4'h7, 16'h0000);
      op(3'h1, 1'b0, 16'h8000, 16'h0, 5'h0, 24'h008000);
      wr(4'h0, 16'h0000);
      rdc(4'h0, 16'h0001);
      wr(4'h1, 16'h0000);
      rdc(4'h1, 16'h0001);
      wr(4'h0, 16'h0002);
      wr(4'h1, 16'h0005);
      op(3'h1, 1'b0, 16'hFFFE, 16'h0, 5'h0, 24'h017FFE);
      op(3'h1, 1'b1, 16'h8010, 16'h0, 5'h0, 24'h028010);
      op(3'h1, 1'b0, 16'h2FFF, 16'h0, 5'h0, 24'h002FFF);
      op(3'h2, 1'b1, 16'h8000, 16'h0, 5'h02, 24'h028000);
      chk(ptr_wb_val, 16'h8002);
      op(3'h3, 1'b0, 16'h1000, 16'h0, 5'h14, 24'h000FFC);
      op(3'h4, 1'b0, 16'h1000, 16'h0020, 5'h0, 24'h001020);
      op(3'h5, 1'b0, 16'h0100, 16'h0010, 5'h0, 24'h000110);
      op(3'h6, 1'b0, 16'hFFFF, 16'h0, 5'h0, 24'h001FFF);
      @(posedge clk);
      op_ptr_sel <= 4'hF;
      op(3'h1, 1'b0, 16'h9000, 16'h0, 5'h0, 24'h009000);
      @(posedge clk);
      op_ptr_sel <= 4'h1;
      cls(1'b0, 1'b0, 3'h4, 4'h1, 5'h00, 1'b1);
      cls(1'b0, 1'b1, 3'h1, 4'h8, 5'h00, 1'b0);
      cls(1'b0, 1'b1, 3'h1, 4'h3, 5'h00, 1'b1);
      cls(1'b0, 1'b1, 3'h4, 4'h9, 5'h00, 1'b0);
      cls(1'b0, 1'b1, 3'h4, 4'h8, 5'h00, 1'b1);
      cls(1'b0, 1'b1, 3'h2, 4'hA, 5'h06, 1'b0);
      cls(1'b0, 1'b1, 3'h2, 4'hA, 5'h03, 1'b1);
      cls(1'b0, 1'b1, 3'h3, 4'hB, 5'h02, 1'b1);
      st(3'h1);
      chk(m(16'h1000), 16'hABCD);
      chk(sp_out, 16'h1002);
      st(3'h3);
      chk({m(16'h1002), m(16'h1004)}, 32'h1234_007A);
      st(3'h4);
      chk({m(16'h1006), m(16'h1008)}, 32'h1234_5A7A);
      chk(sp_out, 16'h100A);
      st(3'h2);
      chk(sp_out, 16'h1008);
      st(3'h5);
      chk(sp_out, 16'h1004);
      @(posedge clk);
      clk_en <= 1'b0;
      st(3'h1);
      chk(sp_out, 16'h1004);
      @(posedge clk);
      clk_en <= 1'b1;
      wr(4'h2, 16'h2001);
      rdc(4'h2, 16'h2000);
      wr(4'h0, 16'h0200);
      op(3'h1, 1'b0, 16'h8000, 16'h0, 5'h0, 24'h0);
      chk(addr_prog_space, 1'b1);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdc(4'h0, 16'h0001);
      rdc(4'h2, 16'h1000);
      chk(sp_out, 16'h1000);
      finish_test;
   end
endmodule
`default_nettype wire
